// *** pkg/epos_defs.svh ***
// Purpose: register offsets, field positions, reset values and timing figures
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   included by the package, the monitor and the bench
`ifndef EPOS_DEFS_SVH
`define EPOS_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define EPOS_OFS_CTRL      12'h000
`define EPOS_OFS_FIFOCTL   12'h004
`define EPOS_OFS_BLANK     12'h008
`define EPOS_OFS_DECIM     12'h00c
`define EPOS_OFS_LPCOEF    12'h010
`define EPOS_OFS_AOSEL     12'h014
`define EPOS_OFS_ECHO      12'h018
`define EPOS_OFS_WPTR      12'h01c
`define EPOS_OFS_TEMP      12'h020
`define EPOS_OFS_STATUS    12'h024

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define EPOS_CTRL_ECHO_EN  0
`define EPOS_AO_SDE        0
`define EPOS_AO_DSS        1
`define EPOS_AO_ROUTE      2
`define EPOS_DECIM_RST     6'h19
`define EPOS_BLANK_RST     8'h00
`define EPOS_MODE_RST      2'h0
`define EPOS_SAT_BYTE      8'hff

// ---------------------------------------------------------------
// Timing: blanking step 16 us, base microsecond tick 1 us at 25 MHz
// ---------------------------------------------------------------
`define EPOS_CLK_MHZ       25
`define EPOS_BLANK_STEP_US 16
`define EPOS_TICK_US       1
`define EPOS_TICK_CYC      (`EPOS_TICK_US * `EPOS_CLK_MHZ)
`define EPOS_STEP_TICKS    (`EPOS_BLANK_STEP_US / `EPOS_TICK_US)

`endif

// *** pkg/epos_pkg.sv ***
// Purpose: types shared by the echo path output stage
// Assumes: constants come from epos_defs.svh
// Notes:   holds types only
package epos_pkg;
  `include "epos_defs.svh"

  // FIFO storage formats
  typedef enum logic [1:0] {
    EPOS_FMT_FULL12 = 2'b00,
    EPOS_FMT_MSB8   = 2'b01,
    EPOS_FMT_LSB8   = 2'b10,
    EPOS_FMT_MID8   = 2'b11
  } epos_fmt_t;

  // Path state
  typedef enum logic [1:0] {
    EPOS_ST_OFF   = 2'b00,
    EPOS_ST_BLANK = 2'b01,
    EPOS_ST_RUN   = 2'b10
  } epos_state_t;
endpackage

// *** hdl/epos_fifo_ram.sv ***
// Purpose: dual-port FIFO byte memory, one write port, one read port
// Assumes: single clock; read data registered
// Notes:   contents survive path restart, never cleared
module epos_fifo_ram #(
  parameter int DEPTH = 768,
  parameter int AW    = 10
) (
  input  wire logic          clk,      // Core clock
  input  wire logic          ce,       // Clock enable
  input  wire logic          wr_en,    // Write strobe
  input  wire logic [AW-1:0] wr_addr,  // Write address
  input  wire logic [7:0]    wr_data,  // Write byte
  input  wire logic [AW-1:0] rd_addr,  // Read address
  output logic      [7:0]    rd_data   // Registered read byte
);
  logic [7:0] mem [DEPTH];

  initial
  begin
    if (DEPTH > (1 << AW)) $error("DEPTH exceeds address width");
  end

  // ---------------------------------------------------------------
  // Write and registered read
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (ce && wr_en && (int'(wr_addr) < DEPTH)) mem[wr_addr] <= wr_data;
    if (ce) rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : 8'h00;
  end
endmodule // epos_fifo_ram

// *** hdl/epos_top.sv ***
// Purpose: echo path output stage: formats samples into FIFO RAM, holds the
//          latest sample, blanking, analog output routing, LPF coefficients
// Assumes: sample arrives as a 12-bit word from same-clock logic with a strobe
// Notes:   APB slave, zero wait states except one for FIFO window reads at 12'h400
module epos_top
  import epos_pkg::*;
#(
  parameter int FIFO_DEPTH = 768,
  parameter int FIFO_AW    = 10
) (
  input  wire logic        REF_CLK,      // Core clock, 25 MHz
  input  wire logic        SYS_RST,      // Async reset, active high
  input  wire logic        CLK_EN,       // Clock enable
  input  wire logic [11:0] SAMPLE_IN,    // Data path sample
  input  wire logic        SAMPLE_VLD,   // Sample strobe
  input  wire logic [7:0]  TEMP_CODE,    // Sensor conversion result
  input  wire logic        TEMP_VLD,     // Conversion done strobe
  input  wire logic [11:0] PADDR,        // APB address
  input  wire logic        PSEL,         // APB select
  input  wire logic        PENABLE,      // APB enable
  input  wire logic        PWRITE,       // APB direction
  input  wire logic [31:0] PWDATA,       // APB write data
  output logic      [31:0] PRDATA,       // APB read data
  output logic             PREADY,       // APB ready
  output logic             PSLVERR,      // APB error
  output logic             PATH_RUN,     // Computation enabled, filters live
  output logic             FILT_CLR,     // Filter history clear
  output logic             DEC_TICK,     // Decimation period strobe
  output logic [15:0]      LP_NUM_COEF,  // Low-pass numerator coefficient
  output logic [15:0]      LP_FB_COEF,   // Low-pass feedback coefficient
  output logic [7:0]       DAC_CODE,     // DAC input code
  output logic             DAC_EN,       // Sensor/DAC enable
  output logic             ANALOG_OUT_ROUTE // Analog pin connected
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic               echo_en_reg;
  epos_fmt_t          mode_reg;
  logic [7:0]         blank_reg;
  logic [5:0]         decim_reg;
  logic [15:0]        num_reg;
  logic [15:0]        fb_reg;
  logic [2:0]         aosel_reg;
  logic [11:0]        echo_reg;
  logic [FIFO_AW-1:0] wptr_reg;
  logic [7:0]         temp_reg;
  epos_state_t        state_reg;
  logic [4:0]         tick_cnt_reg;
  logic [5:0]         dec_cnt_reg;
  logic [3:0]         step_cnt_reg;
  logic [7:0]         blank_cnt_reg;
  logic               first_reg;
  logic               hi_pend_reg;
  logic [7:0]         hi_byte_reg;

  logic               wr_go;
  logic               wr_go_reg;
  logic               en_rise;
  logic               us_tick;
  logic [7:0]         fmt_byte;
  logic               ram_we;
  logic [FIFO_AW-1:0] ram_wa;
  logic [7:0]         ram_wd;
  logic [7:0]         ram_rd;
  logic               apb_wr;
  logic               apb_rd;
  logic               fifo_win;

  initial
  begin
    if (FIFO_AW < 2 || FIFO_DEPTH < 2) $error("FIFO too small");
  end

  // Eight-bit formatting, shared by FIFO and DAC
  function automatic logic [7:0] fmt8(input epos_fmt_t m, input logic [11:0] s);
    logic [7:0] r;
    r = s[11:4];
    case (m)
      EPOS_FMT_LSB8: r = (s[11:8] == 4'h0) ? s[7:0] : `EPOS_SAT_BYTE;
      EPOS_FMT_MID8: r = (s[11:10] == 2'h0) ? s[10:3] : `EPOS_SAT_BYTE;
      default:       r = s[11:4];
    endcase
    return r;
  endfunction

  assign apb_wr   = PSEL && PENABLE && PWRITE;
  assign apb_rd   = PSEL && !PENABLE && !PWRITE;
  assign fifo_win = PADDR[11:10] == 2'b01;
  assign en_rise  = apb_wr && (PADDR == `EPOS_OFS_CTRL) && PWDATA[`EPOS_CTRL_ECHO_EN]
                    && !echo_en_reg;
  assign us_tick  = tick_cnt_reg == 5'(`EPOS_TICK_CYC - 1);
  assign fmt_byte = fmt8(mode_reg, echo_reg);
  assign wr_go    = (state_reg == EPOS_ST_RUN) && DEC_TICK;

  // ---------------------------------------------------------------
  // APB register writes
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      echo_en_reg <= 1'b0;
      mode_reg    <= EPOS_FMT_FULL12;
      blank_reg   <= `EPOS_BLANK_RST;
      decim_reg   <= `EPOS_DECIM_RST;
      num_reg     <= 16'h0000;
      fb_reg      <= 16'h0000;
      aosel_reg   <= 3'h0;
    end
    else if (CLK_EN && apb_wr)
    begin
      case (PADDR)
        `EPOS_OFS_CTRL:    echo_en_reg <= PWDATA[`EPOS_CTRL_ECHO_EN];
        `EPOS_OFS_FIFOCTL: mode_reg    <= epos_fmt_t'(PWDATA[1:0]);
        `EPOS_OFS_BLANK:   blank_reg   <= PWDATA[7:0];
        `EPOS_OFS_DECIM:   decim_reg   <= (PWDATA[5:0] == 6'h00) ? 6'h01 : PWDATA[5:0];
        `EPOS_OFS_LPCOEF:
        begin
          num_reg <= PWDATA[15:0];
          fb_reg  <= PWDATA[31:16];
        end
        `EPOS_OFS_AOSEL:   aosel_reg   <= PWDATA[2:0];
        default:           ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Microsecond tick and decimation counter
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tick_cnt_reg <= 5'h00;
      dec_cnt_reg  <= 6'h00;
      DEC_TICK     <= 1'b0;
    end
    else if (CLK_EN)
    begin
      tick_cnt_reg <= us_tick ? 5'h00 : tick_cnt_reg + 5'h01;
      DEC_TICK     <= 1'b0;
      if (!echo_en_reg)
        dec_cnt_reg <= 6'h00;
      else if (us_tick)
      begin
        if (dec_cnt_reg + 6'h01 >= decim_reg)
        begin
          dec_cnt_reg <= 6'h00;
          DEC_TICK    <= 1'b1;
        end
        else
          dec_cnt_reg <= dec_cnt_reg + 6'h01;
      end
    end
  end

  // Latest sample held; refreshed on each decimation tick
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      echo_reg <= 12'h000;
    else if (CLK_EN && echo_en_reg && DEC_TICK)
      echo_reg <= SAMPLE_IN;
  end

  // ---------------------------------------------------------------
  // Path state: off, blanking, running
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_reg     <= EPOS_ST_OFF;
      step_cnt_reg  <= 4'h0;
      blank_cnt_reg <= 8'h00;
      PATH_RUN      <= 1'b0;
      FILT_CLR      <= 1'b1;
    end
    else if (CLK_EN)
    begin
      PATH_RUN <= echo_en_reg;
      FILT_CLR <= !echo_en_reg;
      case (state_reg)
        EPOS_ST_OFF:
          if (echo_en_reg)
          begin
            step_cnt_reg  <= 4'h0;
            blank_cnt_reg <= blank_reg;
            state_reg     <= (blank_reg == 8'h00) ? EPOS_ST_RUN : EPOS_ST_BLANK;
          end
        EPOS_ST_BLANK:
          if (!echo_en_reg)
            state_reg <= EPOS_ST_OFF;
          else if (us_tick)
          begin
            step_cnt_reg <= step_cnt_reg + 4'h1;
            if (step_cnt_reg == 4'(`EPOS_STEP_TICKS - 1))
            begin
              blank_cnt_reg <= blank_cnt_reg - 8'h01;
              if (blank_cnt_reg == 8'h01) state_reg <= EPOS_ST_RUN;
            end
          end
        EPOS_ST_RUN:
          if (!echo_en_reg) state_reg <= EPOS_ST_OFF;
        default: state_reg <= EPOS_ST_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // FIFO write sequencing and pointer
  // Pointer starts at zero so the first byte lands at 0; first flag
  // keeps the pointer there in eight-bit formats (at 1 in 12-bit format) rather than advancing past it.
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wptr_reg    <= '0;
      wr_go_reg   <= 1'b0;
      first_reg   <= 1'b1;
      hi_pend_reg <= 1'b0;
      hi_byte_reg <= 8'h00;
      ram_we      <= 1'b0;
      ram_wa      <= '0;
      ram_wd      <= 8'h00;
    end
    else if (CLK_EN)
    begin
      ram_we    <= 1'b0;
      // Write one cycle after the tick, once the latest sample has landed
      wr_go_reg <= wr_go;
      if (en_rise)
      begin
        wptr_reg    <= '0;
        first_reg   <= 1'b1;
        hi_pend_reg <= 1'b0;
      end
      else if (hi_pend_reg)
      begin
        // Second byte of a 12-bit sample
        ram_we      <= 1'b1;
        ram_wa      <= wptr_reg;
        ram_wd      <= hi_byte_reg;
        hi_pend_reg <= 1'b0;
      end
      else if (wr_go_reg)
      begin
        ram_we    <= 1'b1;
        first_reg <= 1'b0;
        if (mode_reg == EPOS_FMT_FULL12)
        begin
          ram_wa      <= first_reg ? '0 : wptr_reg + FIFO_AW'(1);
          ram_wd      <= echo_reg[7:0];
          hi_byte_reg <= {4'h0, echo_reg[11:8]};
          hi_pend_reg <= 1'b1;
          wptr_reg    <= first_reg ? FIFO_AW'(1) : wptr_reg + FIFO_AW'(2);
        end
        else
        begin
          ram_wa   <= first_reg ? '0 : wptr_reg + FIFO_AW'(1);
          ram_wd   <= fmt_byte;
          wptr_reg <= first_reg ? '0 : wptr_reg + FIFO_AW'(1);
        end
      end
    end
  end

  epos_fifo_ram #(
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_ram (
    .clk     (REF_CLK),
    .ce      (CLK_EN),
    .wr_en   (ram_we),
    .wr_addr (ram_wa),
    .wr_data (ram_wd),
    .rd_addr (PADDR[FIFO_AW-1:0]),
    .rd_data (ram_rd)
  );

  // ---------------------------------------------------------------
  // Analog output routing and temperature hold
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      DAC_CODE         <= 8'h00;
      DAC_EN           <= 1'b0;
      ANALOG_OUT_ROUTE <= 1'b0;
      temp_reg         <= 8'h00;
      LP_NUM_COEF      <= 16'h0000;
      LP_FB_COEF       <= 16'h0000;
    end
    else if (CLK_EN)
    begin
      LP_NUM_COEF      <= num_reg;
      LP_FB_COEF       <= fb_reg;
      DAC_EN           <= aosel_reg[`EPOS_AO_SDE];
      ANALOG_OUT_ROUTE <= aosel_reg[`EPOS_AO_ROUTE] && aosel_reg[`EPOS_AO_SDE];
      // Data path source only in eight-bit formats, zero in 12-bit format; sensor code when DSS is clear
      if (aosel_reg[`EPOS_AO_DSS] && mode_reg != EPOS_FMT_FULL12)
        DAC_CODE <= fmt_byte;
      else if (!aosel_reg[`EPOS_AO_DSS])
        DAC_CODE <= temp_reg;
      else
        DAC_CODE <= 8'h00;
      // Sensor shares the DAC, so its reading freezes while path drives pin
      if (TEMP_VLD && aosel_reg[`EPOS_AO_SDE]
          && !(aosel_reg[`EPOS_AO_DSS] && aosel_reg[`EPOS_AO_ROUTE]))
        temp_reg <= TEMP_CODE;
    end
  end

  // ---------------------------------------------------------------
  // APB read: register data registered in setup, FIFO byte in first access cycle
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else if (CLK_EN)
    begin
      // FIFO reads wait one cycle because the RAM read data is registered
      PREADY  <= (PSEL && !PENABLE && !(fifo_win && !PWRITE))
                 || (PSEL && PENABLE && !PWRITE && fifo_win && !PREADY);
      PSLVERR <= 1'b0;
      if (apb_rd)
      begin
        PRDATA <= 32'h0000_0000;
        case (PADDR)
          `EPOS_OFS_CTRL:    PRDATA[0]     <= echo_en_reg;
          `EPOS_OFS_FIFOCTL: PRDATA[1:0]   <= mode_reg;
          `EPOS_OFS_BLANK:   PRDATA[7:0]   <= blank_reg;
          `EPOS_OFS_DECIM:   PRDATA[5:0]   <= decim_reg;
          `EPOS_OFS_LPCOEF:  PRDATA        <= {fb_reg, num_reg};
          `EPOS_OFS_AOSEL:   PRDATA[2:0]   <= aosel_reg;
          `EPOS_OFS_ECHO:    PRDATA[11:0]  <= echo_reg;
          `EPOS_OFS_WPTR:    PRDATA[FIFO_AW-1:0] <= wptr_reg;
          `EPOS_OFS_TEMP:    PRDATA[7:0]   <= temp_reg;
          `EPOS_OFS_STATUS:  PRDATA[1:0]   <= state_reg;
          default:           PSLVERR       <= !fifo_win;
        endcase
      end
      else if (PSEL && PENABLE && !PWRITE && fifo_win)
        PRDATA <= {24'h000000, ram_rd};
    end
  end
endmodule // epos_top

// *** dv/epos_monitor.sv ***
// Purpose: port checker for the echo path output stage
// Assumes: one clock, async active-high reset, zero-wait APB slave except FIFO window reads
// Notes:   bound to the top module from the bench top file
`include "epos_defs.svh"
module epos_monitor (
  input wire logic        REF_CLK,          // Core clock
  input wire logic        SYS_RST,          // Async reset
  input wire logic        CLK_EN,           // Clock enable
  input wire logic [11:0] PADDR,            // APB address
  input wire logic        PSEL,             // APB select
  input wire logic        PENABLE,          // APB enable
  input wire logic        PWRITE,           // APB direction
  input wire logic [31:0] PWDATA,           // APB write data
  input wire logic        PREADY,           // APB ready
  input wire logic        PATH_RUN,         // Path enabled
  input wire logic        FILT_CLR,         // Filter clear
  input wire logic        DEC_TICK,         // Decimation strobe
  input wire logic [15:0] LP_NUM_COEF,      // Numerator coefficient
  input wire logic [15:0] LP_FB_COEF,       // Feedback coefficient
  input wire logic        DAC_EN,           // Sensor/DAC enable
  input wire logic        ANALOG_OUT_ROUTE  // Analog pin connected
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  // -------------------------------------------------------------
  // Write decode
  // -------------------------------------------------------------
  // Frozen clock means no write lands, so gate on it
  logic wr_acc;
  assign wr_acc = PSEL && PENABLE && PWRITE && CLK_EN;

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  chk_ready_zero_wait: assert property (
    PSEL && !PENABLE && !(PADDR[11:10] == 2'b01 && !PWRITE) |=> PREADY)
    else $error("access phase without ready");
  chk_coef_copy: assert property (
    wr_acc && PADDR == `EPOS_OFS_LPCOEF |=> ##1 {LP_FB_COEF, LP_NUM_COEF} == $past(PWDATA, 2))
    else $error("coefficient outputs differ from written word");
  chk_route_follow: assert property (
    wr_acc && PADDR == `EPOS_OFS_AOSEL
    |=> ##1 ANALOG_OUT_ROUTE == $past(PWDATA[2] && PWDATA[0], 2)
    && DAC_EN == $past(PWDATA[0], 2))
    else $error("analog routing differs from written select");
  chk_filter_clear: assert property (FILT_CLR != PATH_RUN)
    else $error("filter clear not opposite to path enable");
  chk_enable_write: assert property (
    wr_acc && PADDR == `EPOS_OFS_CTRL |=> ##1 PATH_RUN == $past(PWDATA[0], 2))
    else $error("path enable differs from written bit");
  chk_tick_spacing: assert property (DEC_TICK |=> !DEC_TICK [*8])
    else $error("decimation ticks too close");
  chk_tick_gated: assert property (DEC_TICK |-> PATH_RUN)
    else $error("decimation tick while path disabled");
  chk_route_reset: assert property ($fell(SYS_RST) |-> !ANALOG_OUT_ROUTE && !DAC_EN)
    else $error("analog pin routed after reset");

  // Main scenarios reached
  cov_path_start: cover property ($rose(PATH_RUN));
  cov_tick: cover property (DEC_TICK);
  cov_route: cover property ($rose(ANALOG_OUT_ROUTE));
endmodule // epos_monitor

// *** dv/epos_mcu_model.sv ***
// Purpose: controller model that configures the stage and reads the FIFO
// Assumes: called just after a rising clock edge
// Notes:   released address and data lines show inverted values
module epos_mcu_model (
  input  wire logic        clk,      // Core clock
  output logic      [11:0] paddr,    // APB address
  output logic             psel,     // APB select
  output logic             penable,  // APB enable
  output logic             pwrite,   // APB direction
  output logic      [31:0] pwdata,   // APB write data
  input  wire logic [31:0] prdata,   // APB read data
  input  wire logic        pready,   // APB ready
  input  wire logic        pslverr   // APB error
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end

  // One transfer; request held until ready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    // Idle cycle so no signal is driven twice in one step
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, pwdata, q, e);
  endtask

  // Only tabulated pairs keep the low-pass stable
  task automatic load_coef(input logic [15:0] num, input logic [15:0] fb);
    wr(`EPOS_OFS_LPCOEF, {fb, num});
  endtask

  // Sensor/DAC enable always set with any source choice
  task automatic select_out(input logic src, input logic route);
    wr(`EPOS_OFS_AOSEL, {29'h0, route, src, 1'b1});
  endtask
endmodule // epos_mcu_model

// *** dv/tb.sv ***
// Purpose: self-checking bench for the echo path output stage
// Assumes: decimation set to one, one tick every 25 cycles
// Notes:   FIFO window reads carry one wait state, the master waits for it
`include "epos_defs.svh"
module tb;
  import epos_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, sys_rst, temp_vld, psel, penable, pwrite, pready, pslverr;
  logic        path_run, filt_clr, dec_tick, dac_en, ao_route, e;
  logic [11:0] sample_in, paddr;
  logic [7:0]  temp_code, dac_code;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] lp_num, lp_fb;
  int          err_count = 0;
  int          n_checks = 0;
  logic [1:0]  mmode [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [11:0] msamp [5] = '{12'hab5, 12'h0c7, 12'h1c7, 12'h3f8, 12'h800};
  logic [7:0]  mexp  [5] = '{8'hab, 8'hc7, 8'hff, 8'h7f, 8'hff};

  epos_top u_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1),
    .SAMPLE_IN(sample_in), .SAMPLE_VLD(1'b1), .TEMP_CODE(temp_code), .TEMP_VLD(temp_vld),
    .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PATH_RUN(path_run),
    .FILT_CLR(filt_clr), .DEC_TICK(dec_tick), .LP_NUM_COEF(lp_num), .LP_FB_COEF(lp_fb),
    .DAC_CODE(dac_code), .DAC_EN(dac_en), .ANALOG_OUT_ROUTE(ao_route));
  epos_mcu_model u_mcu (.clk(ref_clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic rdc(input string w, input logic [11:0] a, input logic [31:0] exp);
    u_mcu.rd(a, q, e);
    check(w, q, exp);
  endtask

  // One read of a FIFO byte; the slave inserts its own wait state
  task automatic fifo_chk(input int idx, input logic [7:0] exp);
    rdc("fifo byte", 12'(12'h400 + idx), {24'h0, exp});
  endtask

  task automatic wait_tick();
    @(posedge ref_clk);
    for (int n = 0; n < 2000 && dec_tick !== 1'b1; n++) @(posedge ref_clk);
    check("tick seen", dec_tick, 1);
  endtask

  task automatic run(input logic [1:0] mode, input int n, input logic [7:0] dac);
    u_mcu.wr(`EPOS_OFS_FIFOCTL, {30'h0, mode});
    u_mcu.wr(`EPOS_OFS_CTRL, 32'h1);
    repeat (n) wait_tick();
    repeat (3) @(posedge ref_clk);
    check("dac code", dac_code, dac);
    u_mcu.wr(`EPOS_OFS_CTRL, 32'h0);
  endtask

  task automatic pulse_temp(input logic [7:0] code);
    temp_code <= code;
    temp_vld  <= 1'b1;
    @(posedge ref_clk);
    temp_vld  <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // -------------------------------------------------------------
  // Clock, watchdog, tests
  // -------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Run needs about 1000 cycles; a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end

  initial
  begin
    sys_rst = 1'b1;
    {temp_vld, temp_code, sample_in} = '0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check("route at reset", ao_route, 0);
    check("filter clear", filt_clr, 1);
    rdc("decimation", `EPOS_OFS_DECIM, 32'(`EPOS_DECIM_RST));
    rdc("blanking", `EPOS_OFS_BLANK, 32'(`EPOS_BLANK_RST));
    rdc("mode", `EPOS_OFS_FIFOCTL, 32'(`EPOS_MODE_RST));
    rdc("analog select", `EPOS_OFS_AOSEL, 32'h0);
    rdc("state", `EPOS_OFS_STATUS, 32'h0);
    u_mcu.rd(12'h030, q, e);
    check("unmapped error", e, 1);
    u_mcu.load_coef(16'h18c8, 16'h4e70);
    @(posedge ref_clk);
    check("coef pair", {lp_fb, lp_num}, 32'h4e7018c8);
    u_mcu.wr(`EPOS_OFS_DECIM, 32'h1);
    u_mcu.select_out(1'b1, 1'b1);
    @(posedge ref_clk);
    check("route on", {dac_en, ao_route}, 2'b11);
    // Full 12-bit format, three samples
    sample_in <= 12'habc;
    run(EPOS_FMT_FULL12, 3, 8'h00);
    rdc("pointer 12", `EPOS_OFS_WPTR, 32'h5);
    rdc("latest", `EPOS_OFS_ECHO, 32'habc);
    fifo_chk(0, 8'hbc);
    fifo_chk(5, 8'h0a);
    // Every eight-bit format in range; LSB8 and MID8 also saturating
    foreach (mmode[i])
    begin
      sample_in <= msamp[i];
      run(mmode[i], 1, mexp[i]);
      rdc("pointer 8", `EPOS_OFS_WPTR, 32'h0);
      fifo_chk(0, mexp[i]);
    end
    fifo_chk(2, 8'hbc);
    // Temperature frozen while the path drives the pin
    pulse_temp(8'h33);
    rdc("temp frozen", `EPOS_OFS_TEMP, 32'h0);
    u_mcu.select_out(1'b0, 1'b1);
    pulse_temp(8'h5c);
    rdc("temp loaded", `EPOS_OFS_TEMP, 32'h5c);
    // One blanking step: compute at once, write only after 400 cycles
    u_mcu.wr(`EPOS_OFS_BLANK, 32'h1);
    u_mcu.wr(`EPOS_OFS_FIFOCTL, 32'h1);
    sample_in <= 12'h123;
    u_mcu.wr(`EPOS_OFS_CTRL, 32'h1);
    rdc("state blank", `EPOS_OFS_STATUS, 32'h1);
    check("run level", {path_run, filt_clr}, 2'b10);
    wait_tick();
    wait_tick();
    rdc("latest blank", `EPOS_OFS_ECHO, 32'h123);
    fifo_chk(0, 8'hff);
    repeat (400) @(posedge ref_clk);
    rdc("state run", `EPOS_OFS_STATUS, 32'h2);
    wait_tick();
    repeat (3) @(posedge ref_clk);
    fifo_chk(0, 8'h12);
    // Disabled path ignores new samples
    u_mcu.wr(`EPOS_OFS_CTRL, 32'h0);
    sample_in <= 12'h777;
    repeat (60) @(posedge ref_clk);
    rdc("latest held", `EPOS_OFS_ECHO, 32'h123);
    rdc("state off", `EPOS_OFS_STATUS, 32'h0);
    report_and_stop();
  end
endmodule // tb

bind epos_top epos_monitor u_mon (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
  .PREADY(PREADY), .PATH_RUN(PATH_RUN), .FILT_CLR(FILT_CLR), .DEC_TICK(DEC_TICK),
  .LP_NUM_COEF(LP_NUM_COEF), .LP_FB_COEF(LP_FB_COEF), .DAC_EN(DAC_EN),
  .ANALOG_OUT_ROUTE(ANALOG_OUT_ROUTE));
